// ### pkg/urd_pkg.sv
package urd_pkg;

  // register locations on the three address lines
  localparam logic [2:0] ADDR_LOC0 = 3'h0;
  localparam logic [2:0] ADDR_LOC1 = 3'h1;
  localparam logic [2:0] ADDR_LOC2 = 3'h2;
  localparam logic [2:0] ADDR_LOC3 = 3'h3;
  localparam logic [2:0] ADDR_LOC4 = 3'h4;
  localparam logic [2:0] ADDR_LOC5 = 3'h5;
  localparam logic [2:0] ADDR_LOC6 = 3'h6;
  localparam logic [2:0] ADDR_LOC7 = 3'h7;

  // field positions and key values
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  localparam int LINE_CTL_DIV_BIT = 7;
  localparam int MODEM_CTL_LOOP_BIT = 4;
  localparam int MODEM_CTL_RTS_BIT = 1;
  localparam int MODEM_CTL_DTR_BIT = 0;
  localparam int ENH_FUNC_ENABLE_BIT = 4;
  localparam int FEATURE_LEVEL_SEL_BIT = 6;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [4:0] {
    SEL_NONE = 5'h00,
    SEL_RX_HOLD = 5'h01,
    SEL_TX_HOLD = 5'h02,
    SEL_DIV_LOW = 5'h03,
    SEL_DIV_HIGH = 5'h04,
    SEL_REVISION = 5'h05,
    SEL_IDENT = 5'h06,
    SEL_DIV_FRAC = 5'h07,
    SEL_INT_EN = 5'h08,
    SEL_INT_STAT = 5'h09,
    SEL_FIFO_CTL = 5'h0a,
    SEL_LINE_CTL = 5'h0b,
    SEL_MODEM_CTL = 5'h0c,
    SEL_LINE_STAT = 5'h0d,
    SEL_MODEM_STAT = 5'h0e,
    SEL_MODEM_STAT_WR = 5'h0f,
    SEL_SCRATCH = 5'h10,
    SEL_MODE_SEL = 5'h11,
    SEL_LEVEL = 5'h12,
    SEL_TRIGGER = 5'h13,
    SEL_FEATURE = 5'h14,
    SEL_ENH_FUNC = 5'h15,
    SEL_RESUME1 = 5'h16,
    SEL_RESUME2 = 5'h17,
    SEL_PAUSE1 = 5'h18,
    SEL_PAUSE2 = 5'h19
  } urd_sel_type;

  // strobe syncs are stored active high so an all-zero reset is idle
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic rd_s1;
    logic rd_s2;
    logic wr_s1;
    logic wr_s2;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic rd_act;
    logic wr_act;
    logic [7:0] rdata;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] div_frac;
    logic [7:0] int_en;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] enh_func;
    logic [7:0] feature;
    logic [7:0] scratch;
    logic [7:0] mode_sel;
    logic [7:0] modem_wr;
    logic [7:0] trigger;
    logic [7:0] tx_data;
    logic [7:0] fifo_ctl;
    logic [3:0][7:0] flow;
    logic tx_wr;
    logic rx_rd;
    logic fifo_wr;
    logic fifo_trigger_level_wr;
    logic line_stat_rd;
    logic modem_stat_rd;
    logic int_stat_rd;
  } urd_state_type;

  localparam urd_state_type URD_STATE_RST = '0;

  // pins stored inverted so that reset leaves them idle
  typedef struct packed {
    logic rx_low_s1;
    logic rx_low_s2;
    logic [3:0] modem_s1;
    logic [3:0] modem_s2;
    logic tx_low;
    logic rts_on;
    logic dtr_on;
    logic rx_low;
    logic [3:0] modem_on;
  } urd_loop_state_type;

  localparam urd_loop_state_type URD_LOOP_RST = '0;

endpackage

// ### hdl/urd_loop.sv
`timescale 1ns/100ps
`default_nettype none
module urd_loop (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_loop_en,
  input wire logic i_rts_req,
  input wire logic i_dtr_req,
  input wire logic i_tx_shift,
  input wire logic i_rx_pin,
  input wire logic [3:0] i_modem_n,
  output logic o_tx_pin,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_rx_shift,
  output logic [3:0] o_modem_n
);
  import urd_pkg::*;

  urd_loop_state_type st_r;
  urd_loop_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_low_s1 = ~i_rx_pin;
    st_nxt.rx_low_s2 = st_r.rx_low_s1;
    st_nxt.modem_s1 = ~i_modem_n;
    st_nxt.modem_s2 = st_r.modem_s1;
    if (i_loop_en) begin
      // shifter output goes straight back, pins idle
      st_nxt.rx_low = ~i_tx_shift;
      st_nxt.tx_low = 1'b0;
      st_nxt.rts_on = 1'b0;
      st_nxt.dtr_on = 1'b0;
      // outside modem activity must not reach the core
      st_nxt.modem_on = 4'h0;
    end else begin
      st_nxt.rx_low = st_r.rx_low_s2;
      st_nxt.tx_low = ~i_tx_shift;
      st_nxt.rts_on = i_rts_req;
      st_nxt.dtr_on = i_dtr_req;
      st_nxt.modem_on = st_r.modem_s2;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r <= URD_LOOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tx_pin = ~st_r.tx_low;
  assign o_rts_n = ~st_r.rts_on;
  assign o_dtr_n = ~st_r.dtr_on;
  assign o_rx_shift = ~st_r.rx_low;
  assign o_modem_n = ~st_r.modem_on;

endmodule
`default_nettype wire

// ### hdl/urd_regbank.sv
`timescale 1ns/100ps
`default_nettype none
module urd_regbank #(
  // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01,
  // arbitrary value
  parameter logic [7:0] DEVICE_IDENT = 8'h5a
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic [7:0] i_rx_hold,
  input wire logic [7:0] i_int_status,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_modem_status,
  input wire logic [7:0] i_fifo_level,
  output logic [7:0] o_tx_hold_data,
  output logic o_tx_hold_wr,
  output logic o_rx_hold_rd,
  output logic [7:0] o_fifo_ctl_data,
  output logic o_fifo_ctl_wr,
  output logic [7:0] o_trigger_data,
  output logic o_trigger_wr,
  output logic o_line_stat_rd,
  output logic o_modem_stat_rd,
  output logic o_int_stat_rd,
  output logic [15:0] o_divisor,
  output logic [7:0] o_divisor_frac,
  output logic [7:0] o_int_enable,
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [7:0] o_enh_function,
  output logic [7:0] o_feature_control,
  output logic [7:0] o_mode_select,
  output logic [7:0] o_modem_stat_wr_data,
  output logic [31:0] o_flow_chars,
  output logic o_loopback,
  input wire logic i_tx_shift,
  output logic o_rx_shift,
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  output logic o_rts_n,
  output logic o_dtr_n,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_carrier_detect_n,
  input wire logic i_ring_indicator_n,
  output logic o_cts_n,
  output logic o_dsr_n,
  output logic o_carrier_detect_n,
  output logic o_ring_indicator_n
);
  import urd_pkg::*;

  urd_state_type st_r;
  urd_state_type st_nxt;
  logic rd_now;
  logic wr_now;
  logic rd_evt;
  logic wr_evt;
  logic div_zero;
  logic is_enh;
  urd_sel_type rsel;
  urd_sel_type wsel;
  logic [3:0] modem_out_n;

  // same map serves reads and writes; only the read side sees the id codes
  function automatic urd_sel_type urd_decode(input logic [2:0] addr,
                                             input logic [7:0] line_control,
                                             input logic efr_en,
                                             input logic level_sel,
                                             input logic dzero,
                                             input logic is_wr);
    logic enh;
    logic dvb;
    enh = (line_control == LCR_ENH_KEY);
    dvb = line_control[LINE_CTL_DIV_BIT] && !enh;
    urd_decode = SEL_NONE;
    case (addr)
      ADDR_LOC0: begin
        if (enh) begin
          urd_decode = is_wr ? SEL_TRIGGER : SEL_LEVEL;
        end else if (dvb) begin
          urd_decode = (!is_wr && dzero) ? SEL_REVISION : SEL_DIV_LOW;
        end else begin
          urd_decode = is_wr ? SEL_TX_HOLD : SEL_RX_HOLD;
        end
      end
      ADDR_LOC1: begin
        if (enh) begin
          urd_decode = SEL_FEATURE;
        end else if (dvb) begin
          urd_decode = (!is_wr && dzero) ? SEL_IDENT : SEL_DIV_HIGH;
        end else begin
          urd_decode = SEL_INT_EN;
        end
      end
      ADDR_LOC2: begin
        if (enh) begin
          urd_decode = SEL_ENH_FUNC;
        end else if (dvb && efr_en) begin
          urd_decode = SEL_DIV_FRAC;
        end else if (efr_en ? !line_control[LINE_CTL_DIV_BIT] : !enh) begin
          urd_decode = is_wr ? SEL_FIFO_CTL : SEL_INT_STAT;
        end else begin
          urd_decode = SEL_NONE;
        end
      end
      ADDR_LOC3: begin
        urd_decode = SEL_LINE_CTL;
      end
      ADDR_LOC4: begin
        urd_decode = enh ? SEL_RESUME1 : SEL_MODEM_CTL;
      end
      ADDR_LOC5: begin
        if (enh) begin
          urd_decode = SEL_RESUME2;
        end else begin
          urd_decode = is_wr ? SEL_NONE : SEL_LINE_STAT;
        end
      end
      ADDR_LOC6: begin
        if (enh) begin
          urd_decode = SEL_PAUSE1;
        end else if (!is_wr) begin
          urd_decode = SEL_MODEM_STAT;
        end else begin
          urd_decode = efr_en ? SEL_MODEM_STAT_WR : SEL_NONE;
        end
      end
      ADDR_LOC7: begin
        if (enh) begin
          urd_decode = SEL_PAUSE2;
        end else if (is_wr) begin
          urd_decode = level_sel ? SEL_MODE_SEL : SEL_SCRATCH;
        end else begin
          urd_decode = level_sel ? SEL_LEVEL : SEL_SCRATCH;
        end
      end
      default: begin
        urd_decode = SEL_NONE;
      end
    endcase
  endfunction

  // bus pins come from another domain; hold addr and data over the strobe
  assign rd_now = st_r.cs_s2 && st_r.rd_s2;
  assign wr_now = st_r.cs_s2 && st_r.wr_s2;
  assign rd_evt = rd_now && !st_r.rd_act;
  assign wr_evt = wr_now && !st_r.wr_act;
  assign div_zero = (st_r.div_low == DIV_ZERO) && (st_r.div_high == DIV_ZERO);
  assign is_enh = (st_r.line_ctl == LCR_ENH_KEY);
  assign rsel = urd_decode(st_r.addr_s2, st_r.line_ctl, st_r.enh_func[ENH_FUNC_ENABLE_BIT],
                           st_r.feature[FEATURE_LEVEL_SEL_BIT], div_zero, 1'b0);
  assign wsel = urd_decode(st_r.addr_s2, st_r.line_ctl, st_r.enh_func[ENH_FUNC_ENABLE_BIT],
                           st_r.feature[FEATURE_LEVEL_SEL_BIT], div_zero, 1'b1);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s1 = ~i_cs_n;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.rd_s1 = ~i_rd_n;
    st_nxt.rd_s2 = st_r.rd_s1;
    st_nxt.wr_s1 = ~i_wr_n;
    st_nxt.wr_s2 = st_r.wr_s1;
    st_nxt.addr_s1 = i_addr;
    st_nxt.addr_s2 = st_r.addr_s1;
    st_nxt.data_s1 = i_data;
    st_nxt.data_s2 = st_r.data_s1;
    st_nxt.rd_act = rd_now;
    st_nxt.wr_act = wr_now;
    st_nxt.tx_wr = 1'b0;
    st_nxt.rx_rd = 1'b0;
    st_nxt.fifo_wr = 1'b0;
    st_nxt.fifo_trigger_level_wr = 1'b0;
    st_nxt.line_stat_rd = 1'b0;
    st_nxt.modem_stat_rd = 1'b0;
    st_nxt.int_stat_rd = 1'b0;
    if (wr_evt) begin
      case (wsel)
        SEL_TX_HOLD: begin
          st_nxt.tx_data = st_r.data_s2;
          st_nxt.tx_wr = 1'b1;
        end
        SEL_DIV_LOW: st_nxt.div_low = st_r.data_s2;
        SEL_DIV_HIGH: st_nxt.div_high = st_r.data_s2;
        SEL_DIV_FRAC: st_nxt.div_frac = st_r.data_s2;
        SEL_INT_EN: st_nxt.int_en = st_r.data_s2;
        SEL_FIFO_CTL: begin
          st_nxt.fifo_ctl = st_r.data_s2;
          st_nxt.fifo_wr = 1'b1;
        end
        SEL_LINE_CTL: st_nxt.line_ctl = st_r.data_s2;
        SEL_MODEM_CTL: st_nxt.modem_ctl = st_r.data_s2;
        SEL_MODEM_STAT_WR: st_nxt.modem_wr = st_r.data_s2;
        SEL_SCRATCH: st_nxt.scratch = st_r.data_s2;
        SEL_MODE_SEL: st_nxt.mode_sel = st_r.data_s2;
        SEL_TRIGGER: begin
          st_nxt.trigger = st_r.data_s2;
          st_nxt.fifo_trigger_level_wr = 1'b1;
        end
        SEL_FEATURE: st_nxt.feature = st_r.data_s2;
        SEL_ENH_FUNC: st_nxt.enh_func = st_r.data_s2;
        SEL_RESUME1: st_nxt.flow[0] = st_r.data_s2;
        SEL_RESUME2: st_nxt.flow[1] = st_r.data_s2;
        SEL_PAUSE1: st_nxt.flow[2] = st_r.data_s2;
        SEL_PAUSE2: st_nxt.flow[3] = st_r.data_s2;
        // read-only selections store nothing
        default: st_nxt.tx_wr = 1'b0;
      endcase
    end
    if (rd_evt) begin
      case (rsel)
        SEL_RX_HOLD: begin
          st_nxt.rdata = i_rx_hold;
          st_nxt.rx_rd = 1'b1;
        end
        SEL_REVISION: st_nxt.rdata = REVISION_CODE;
        SEL_IDENT: st_nxt.rdata = DEVICE_IDENT;
        SEL_DIV_LOW: st_nxt.rdata = st_r.div_low;
        SEL_DIV_HIGH: st_nxt.rdata = st_r.div_high;
        SEL_DIV_FRAC: st_nxt.rdata = st_r.div_frac;
        SEL_INT_EN: st_nxt.rdata = st_r.int_en;
        SEL_INT_STAT: begin
          st_nxt.rdata = i_int_status;
          st_nxt.int_stat_rd = 1'b1;
        end
        SEL_LINE_CTL: st_nxt.rdata = st_r.line_ctl;
        SEL_MODEM_CTL: st_nxt.rdata = st_r.modem_ctl;
        SEL_LINE_STAT: begin
          st_nxt.rdata = i_line_status;
          st_nxt.line_stat_rd = 1'b1;
        end
        SEL_MODEM_STAT: begin
          st_nxt.rdata = i_modem_status;
          st_nxt.modem_stat_rd = 1'b1;
        end
        SEL_SCRATCH: st_nxt.rdata = st_r.scratch;
        SEL_LEVEL: st_nxt.rdata = i_fifo_level;
        SEL_FEATURE: st_nxt.rdata = st_r.feature;
        SEL_ENH_FUNC: st_nxt.rdata = st_r.enh_func;
        SEL_RESUME1: st_nxt.rdata = st_r.flow[0];
        SEL_RESUME2: st_nxt.rdata = st_r.flow[1];
        SEL_PAUSE1: st_nxt.rdata = st_r.flow[2];
        SEL_PAUSE2: st_nxt.rdata = st_r.flow[3];
        default: st_nxt.rdata = REG_RST;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r <= URD_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // only the pins are rerouted; the core keeps running as usual
  urd_loop urd_loop_inst (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_loop_en(st_r.modem_ctl[MODEM_CTL_LOOP_BIT]),
    .i_rts_req(st_r.modem_ctl[MODEM_CTL_RTS_BIT]),
    .i_dtr_req(st_r.modem_ctl[MODEM_CTL_DTR_BIT]),
    .i_tx_shift(i_tx_shift),
    .i_rx_pin(i_rx_pin),
    .i_modem_n({i_ring_indicator_n, i_carrier_detect_n, i_dsr_n, i_cts_n}),
    .o_tx_pin(o_tx_pin),
    .o_rts_n(o_rts_n),
    .o_dtr_n(o_dtr_n),
    .o_rx_shift(o_rx_shift),
    .o_modem_n(modem_out_n)
  );

  assign o_cts_n = modem_out_n[0];
  assign o_dsr_n = modem_out_n[1];
  assign o_carrier_detect_n = modem_out_n[2];
  assign o_ring_indicator_n = modem_out_n[3];
  assign o_data = st_r.rdata;
  assign o_data_oe = st_r.rd_act;
  assign o_tx_hold_data = st_r.tx_data;
  assign o_tx_hold_wr = st_r.tx_wr;
  assign o_rx_hold_rd = st_r.rx_rd;
  assign o_fifo_ctl_data = st_r.fifo_ctl;
  assign o_fifo_ctl_wr = st_r.fifo_wr;
  assign o_trigger_data = st_r.trigger;
  assign o_trigger_wr = st_r.fifo_trigger_level_wr;
  assign o_line_stat_rd = st_r.line_stat_rd;
  assign o_modem_stat_rd = st_r.modem_stat_rd;
  assign o_int_stat_rd = st_r.int_stat_rd;
  assign o_divisor = {st_r.div_high, st_r.div_low};
  assign o_divisor_frac = st_r.div_frac;
  assign o_int_enable = st_r.int_en;
  assign o_line_control = st_r.line_ctl;
  assign o_modem_control = st_r.modem_ctl;
  assign o_enh_function = st_r.enh_func;
  assign o_feature_control = st_r.feature;
  assign o_mode_select = st_r.mode_sel;
  assign o_modem_stat_wr_data = st_r.modem_wr;
  assign o_flow_chars = st_r.flow;
  assign o_loopback = st_r.modem_ctl[MODEM_CTL_LOOP_BIT];

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_loop_flag: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC4 && !is_enh
    |=> o_loopback == $past(st_r.data_s2[MODEM_CTL_LOOP_BIT])) else $error("loopback flag");
  a_loop_route: assert property (o_loopback && $past(o_loopback)
    |=> o_rx_shift == $past(i_tx_shift)) else $error("loopback data path");
  a_loop_pins: assert property (o_loopback ##1 o_loopback
    |=> o_tx_pin && o_rts_n && o_dtr_n) else $error("loopback pins not idle");
  a_loop_modem: assert property (o_loopback ##1 o_loopback
    |=> (modem_out_n == 4'hf)) else $error("modem inputs leak");
  a_div_write: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC0 && !is_enh
    && st_r.line_ctl[LINE_CTL_DIV_BIT] |=> o_divisor[7:0] == $past(st_r.data_s2))
    else $error("divisor low write");
  a_ident_read: assert property (rd_evt && st_r.addr_s2 == ADDR_LOC1 && !is_enh && div_zero
    && st_r.line_ctl[LINE_CTL_DIV_BIT] |=> o_data == DEVICE_IDENT && o_data_oe)
    else $error("ident read");
  a_frac_gate: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC2
    && !st_r.enh_func[ENH_FUNC_ENABLE_BIT] |=> $stable(o_divisor_frac))
    else $error("fraction written without enable");
  a_tx_write: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC0
    && !st_r.line_ctl[LINE_CTL_DIV_BIT] |=> o_tx_hold_wr ##1 !o_tx_hold_wr)
    else $error("transmit holding strobe");
  a_line_ctl_any: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC3
    |=> o_line_control == $past(st_r.data_s2)) else $error("line control write");
  a_line_stat_rd: assert property (rd_evt && st_r.addr_s2 == ADDR_LOC5 && !is_enh
    |=> o_data == $past(i_line_status) && o_line_stat_rd) else $error("line status read");
  a_pause_store: assert property (wr_evt && st_r.addr_s2 == ADDR_LOC7 && is_enh
    |=> o_flow_chars[31:24] == $past(st_r.data_s2)) else $error("pause char two");

  c_loop_enter: cover property (!o_loopback ##1 o_loopback);
  c_enh_write: cover property (wr_evt && is_enh);
  c_rev_read: cover property (rd_evt && rsel == SEL_REVISION);
  c_level_read: cover property (rd_evt && rsel == SEL_LEVEL && !is_enh);

endmodule
`default_nettype wire

// ### dv/urd_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module urd_line_model #(
  parameter logic [7:0] RX_VAL = 8'h3c,
  parameter logic [7:0] IS_VAL = 8'hc1,
  parameter logic [7:0] LS_VAL = 8'h60,
  parameter logic [7:0] MS_VAL = 8'hb0,
  parameter logic [7:0] FL_VAL = 8'h21
) (
  input wire logic i_ref_clk,
  output logic o_rx_pin,
  output logic [3:0] o_modem_n,
  output logic [7:0] o_rx_hold,
  output logic [7:0] o_int_status,
  output logic [7:0] o_line_status,
  output logic [7:0] o_modem_status,
  output logic [7:0] o_fifo_level
);
  // line held at mark so leaving loopback sees no false break
  assign o_rx_pin = 1'b1;
  assign o_rx_hold = RX_VAL;
  assign o_int_status = IS_VAL;
  assign o_line_status = LS_VAL;
  assign o_modem_status = MS_VAL;
  assign o_fifo_level = FL_VAL;
  // modem lines busy every cycle, so a leak past loopback shows
  initial o_modem_n = 4'h5;
  always @(posedge i_ref_clk) begin
    #1 o_modem_n <= ~o_modem_n;
  end
endmodule
`default_nettype wire

// ### dv/uart_register_decode_loopback_test.sv
`timescale 1ns/100ps
`default_nettype none
module uart_register_decode_loopback_test;
  import urd_pkg::*;
  localparam logic [7:0] RXV = 8'h3c, ISV = 8'hc1, LSV = 8'h60, MSV = 8'hb0, FLV = 8'h21;
  logic clk = 1'b0, rstn = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, txs = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] din = 8'h00;
  logic rx_pin, oe, tx_wr, rx_rd, fifo_wr, fifo_trigger_level_wr, ls_rd, ms_rd, is_rd, loopb, rxs;
  logic tx_pin, rts_n, dtr_n, cts_o, dsr_o, cd_o, ri_o;
  logic [3:0] modem_n;
  logic [7:0] dout, rxh, ist, lst, mst, flv, txd, fcd, trd, frac, ien, line_control, modem_control, enhanced_function, fct;
  logic [7:0] msel, mswd;
  logic [15:0] divisor;
  logic [31:0] flow;
  int n_errors = 0;
  int cmp_count = 0;
  logic [6:0] strobes;
  int str_cnt [7];
  logic [2:0][3:0] modem_hist;
  assign strobes = {tx_wr, rx_rd, fifo_wr, fifo_trigger_level_wr, ls_rd, ms_rd, is_rd};
  // counted per cycle, so a strobe that stands too long shows as extra
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      str_cnt[i] <= str_cnt[i] + int'(strobes[i] === 1'b1);
    end
  end
  // modem pins reach the core through three flops
  always @(posedge clk) begin
    modem_hist <= {modem_hist[1:0], modem_n};
  end
  always #4 clk = ~clk;
  urd_line_model #(.RX_VAL(RXV), .IS_VAL(ISV), .LS_VAL(LSV), .MS_VAL(MSV), .FL_VAL(FLV))
    urd_line_model_inst (.i_ref_clk(clk), .o_rx_pin(rx_pin), .o_modem_n(modem_n),
    .o_rx_hold(rxh), .o_int_status(ist), .o_line_status(lst), .o_modem_status(mst),
    .o_fifo_level(flv));
  urd_regbank urd_regbank_inst (.i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(din), .o_data(dout),
    .o_data_oe(oe), .i_rx_hold(rxh), .i_int_status(ist), .i_line_status(lst),
    .i_modem_status(mst), .i_fifo_level(flv), .o_tx_hold_data(txd), .o_tx_hold_wr(tx_wr),
    .o_rx_hold_rd(rx_rd), .o_fifo_ctl_data(fcd), .o_fifo_ctl_wr(fifo_wr),
    .o_trigger_data(trd), .o_trigger_wr(fifo_trigger_level_wr), .o_line_stat_rd(ls_rd),
    .o_modem_stat_rd(ms_rd), .o_int_stat_rd(is_rd), .o_divisor(divisor),
    .o_divisor_frac(frac), .o_int_enable(ien), .o_line_control(line_control),
    .o_modem_control(modem_control), .o_enh_function(enhanced_function), .o_feature_control(fct),
    .o_mode_select(msel), .o_modem_stat_wr_data(mswd), .o_flow_chars(flow),
    .o_loopback(loopb), .i_tx_shift(txs), .o_rx_shift(rxs), .i_rx_pin(rx_pin),
    .o_tx_pin(tx_pin), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .i_cts_n(modem_n[0]),
    .i_dsr_n(modem_n[1]), .i_carrier_detect_n(modem_n[2]), .i_ring_indicator_n(modem_n[3]),
    .o_cts_n(cts_o), .o_dsr_n(dsr_o), .o_carrier_detect_n(cd_o), .o_ring_indicator_n(ri_o));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // address and data settle three cycles ahead of the strobe and outlive it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr = a;
    din = d;
    tick(3);
    cs_n = 1'b0;
    wr_n = 1'b0;
    tick(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    tick(4);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr = a;
    tick(3);
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick(5);
    d = dout;
    check("data_oe", oe, 1'b1);
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(4);
  endtask
  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(name, v, exp);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    rstn = 1'b1;
    tick(3);
    check("divisor_rst", divisor, 16'h0000);
    check("tx_pin_rst", {tx_pin, rts_n, dtr_n, loopb}, 4'he);
    // normal bank
    wr(ADDR_LOC0, 8'ha5);
    check("tx_holding", txd, 8'ha5);
    rchk("rx_holding", ADDR_LOC0, RXV);
    wr(ADDR_LOC1, 8'h0f);
    rchk("int_enable", ADDR_LOC1, 8'h0f);
    wr(ADDR_LOC2, 8'hc7);
    check("fifo_ctl", fcd, 8'hc7);
    rchk("int_status", ADDR_LOC2, ISV);
    rchk("line_status", ADDR_LOC5, LSV);
    wr(ADDR_LOC6, 8'h99);
    check("msr_wr_gated", mswd, 8'h00);
    rchk("modem_status", ADDR_LOC6, MSV);
    wr(ADDR_LOC7, 8'h5e);
    rchk("scratch", ADDR_LOC7, 8'h5e);
    // divisor bank with both bytes zero shows identity codes
    wr(ADDR_LOC3, 8'h80);
    rchk("revision", ADDR_LOC0, 8'h01);
    rchk("ident", ADDR_LOC1, 8'h5a);
    rchk("div_int_status", ADDR_LOC2, ISV);
    wr(ADDR_LOC0, 8'h34);
    wr(ADDR_LOC1, 8'h12);
    check("divisor", divisor, 16'h1234);
    rchk("div_low", ADDR_LOC0, 8'h34);
    rchk("div_high", ADDR_LOC1, 8'h12);
    check("int_en_kept", ien, 8'h0f);
    // enhanced bank
    wr(ADDR_LOC3, LCR_ENH_KEY);
    rchk("line_ctl", ADDR_LOC3, LCR_ENH_KEY);
    wr(ADDR_LOC2, 8'h10);
    rchk("enh_func", ADDR_LOC2, 8'h10);
    wr(ADDR_LOC1, 8'h40);
    rchk("feature", ADDR_LOC1, 8'h40);
    rchk("level_enh", ADDR_LOC0, FLV);
    wr(ADDR_LOC0, 8'h2b);
    check("trigger", trd, 8'h2b);
    check("divisor_kept", divisor, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      wr(3'(4 + i), 8'(8'h11 * (i + 1)));
    end
    check("flow_chars", flow, 32'h44332211);
    rchk("pause_two", ADDR_LOC7, 8'h44);
    rchk("resume_two", ADDR_LOC5, 8'h22);
    // divisor bank with enhance bit: fraction
    wr(ADDR_LOC3, 8'h80);
    wr(ADDR_LOC2, 8'h77);
    check("div_frac", frac, 8'h77);
    rchk("div_frac_rd", ADDR_LOC2, 8'h77);
    // normal bank with enhance and level select
    wr(ADDR_LOC3, 8'h03);
    wr(ADDR_LOC5, 8'hff);
    check("lsr_wr_ignored", line_control, 8'h03);
    wr(ADDR_LOC6, 8'h99);
    check("msr_wr", mswd, 8'h99);
    rchk("level", ADDR_LOC7, FLV);
    wr(ADDR_LOC7, 8'h3a);
    check("mode_sel", msel, 8'h3a);
    // loopback
    wr(ADDR_LOC4, 8'h03);
    check("rts_dtr_on", {rts_n, dtr_n, loopb}, 3'h0);
    check("modem_follows", {ri_o, cd_o, dsr_o, cts_o}, modem_hist[2]);
    wr(ADDR_LOC4, 8'h13);
    check("loopback", loopb, 1'b1);
    txs = 1'b0;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      check("loop_pins", {tx_pin, rts_n, dtr_n}, 3'h7);
      check("loop_modem", {cts_o, dsr_o, cd_o, ri_o}, 4'hf);
    end
    check("loop_rx0", rxs, 1'b0);
    txs = 1'b1;
    tick(2);
    check("loop_rx1", rxs, 1'b1);
    wr(ADDR_LOC7, 8'h6c);
    check("loop_mode_sel", msel, 8'h6c);
    rchk("loop_line_stat", ADDR_LOC5, LSV);
    txs = 1'b0;
    wr(ADDR_LOC4, 8'h03);
    check("loop_exit", {loopb, rts_n, dtr_n, tx_pin}, 4'h0);
    check("rx_path_pin", rxs, 1'b1);
    check("modem_ctl", modem_control, 8'h03);
    check("enh_func_kept", enhanced_function, 8'h10);
    check("feature_kept", fct, 8'h40);
    check("tx_hold_wr_cnt", str_cnt[6], 1);
    check("rx_hold_rd_cnt", str_cnt[5], 1);
    check("fifo_ctl_wr_cnt", str_cnt[4], 1);
    check("trigger_wr_cnt", str_cnt[3], 1);
    check("line_stat_rd_cnt", str_cnt[2], 2);
    check("modem_stat_rd_cnt", str_cnt[1], 1);
    check("int_stat_rd_cnt", str_cnt[0], 2);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
